// file: pkg/isr_pkg.sv
// Package for the inductive sensor readout block: register map, fields, enums.
// Assumes a 32-bit APB register bus; every register takes one aligned word.
package isr_pkg;

    // Printed offsets are not all multiples of four: they are word indexes
    localparam logic [7:0] IDX_IMPEDANCE_CEILING_SETTING     = 8'h01;
    localparam logic [7:0] IDX_IMPEDANCE_FLOOR_SETTING     = 8'h02;
    localparam logic [7:0] IDX_SENSOR_CFG = 8'h04;
    localparam logic [7:0] IDX_TB_CFG     = 8'h05;
    localparam logic [7:0] IDX_THR_HI_L   = 8'h06;
    localparam logic [7:0] IDX_THR_HI_H   = 8'h07;
    localparam logic [7:0] IDX_THR_LO_L   = 8'h08;
    localparam logic [7:0] IDX_THR_LO_H   = 8'h09;
    localparam logic [7:0] IDX_INT_CFG    = 8'h0A;
    localparam logic [7:0] IDX_EVT_STAT   = 8'h10;
    localparam logic [7:0] IDX_EVT_MASK   = 8'h11;
    localparam logic [7:0] IDX_STATUS     = 8'h20;
    localparam logic [7:0] IDX_PROX_L     = 8'h21;
    localparam logic [7:0] IDX_PROX_H     = 8'h22;
    localparam logic [7:0] IDX_FREQ_L     = 8'h23;
    localparam logic [7:0] IDX_FREQ_M     = 8'h24;
    localparam logic [7:0] IDX_FREQ_H     = 8'h25;
    localparam int         ADDR_LSB       = 2;

    // Reset values and the full-scale result
    localparam logic [7:0]  RST_IMPEDANCE_CEILING_SETTING     = 8'h0E;
    localparam logic [7:0]  RST_IMPEDANCE_FLOOR_SETTING     = 8'h14;
    localparam logic [7:0]  RST_SENSOR_CFG = 8'h1B;
    localparam logic [7:0]  RST_TB_CFG     = 8'h01;
    localparam logic [15:0] RST_THR_HI     = 16'hFFFF;
    localparam logic [15:0] RST_THR_LO     = 16'h0000;
    localparam logic [15:0] PROX_FULL      = 16'hFFFF;

    // Field positions
    localparam int RESP_LSB   = 0;
    localparam int RESP_W     = 3;
    localparam int TB_SEL_BIT = 1;
    localparam int TB_PD_BIT  = 0;

    // Event bits in status / mask
    localparam int EV_DATA = 0;
    localparam int EV_CMP  = 1;
    localparam int EV_WAKE = 2;
    localparam int EV_W    = 3;

    typedef enum logic [2:0] {
        ISR_INT_DATA_READY_BEHAVIOUR = 3'h0,
        ISR_INT_CMP  = 3'h1,
        ISR_INT_WAKE = 3'h2
    } isr_int_mode_t;

    typedef enum {ISR_IDLE, ISR_SETTLE} isr_irq_st_t;

    // One finished conversion from the analog front end
    typedef struct packed {
        logic [15:0] prox;
        logic [23:0] count;
        logic        below_floor;
    } isr_conv_t;

    // Timebase pin control
    typedef struct packed {
        logic crystalSel;
        logic oscPowerDown;
        logic [2:0] respTime;
    } isr_tb_ctl_t;

    localparam logic [31:0] APB_ZERO = 32'h0000_0000;

endpackage

// file: sim/inductive_sensor_readout_interrupt_output_tb.sv
// Bench for isr_readout: APB master tasks, conversions via the front-end model.
// Assumes a 40 MHz ref_clk and word-index register addresses.
`timescale 1ns/1ps
module inductive_sensor_readout_interrupt_output_tb;
    import isr_pkg::*;
    logic ref_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, go = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata;
    logic pready, pslverr, convValid, interruptOutput, irq, errv;
    logic [7:0] rdv, floorSet, ceilSet;
    isr_conv_t val = '0, convData;
    isr_tb_ctl_t tbCtl;
    int miscompares = 0, comparisons = 0;
    always #12.5 ref_clk = ~ref_clk;
    isr_readout dut (.ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .convValid(convValid), .convData(convData), .tbCtl(tbCtl),
        .impedanceFloorSetting(floorSet), .impedanceCeilingSetting(ceilSet),
        .interruptOutput(interruptOutput), .irq(irq));
    isr_front_end_model fe (.ref_clk(ref_clk), .req(go), .val(val),
        .convValid(convValid), .convData(convData));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // Read data and error are taken at the edge where pready is seen high
    task automatic apb(input logic w, input logic [7:0] ix, input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, ix, 2'h0};
        pwdata <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        errv = pslverr;
        rdv = prdata[7:0];
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd(input logic [7:0] ix, input logic [7:0] e, input string n);
        apb(1'b0, ix, 8'h00);
        chk(n, e, rdv);
    endtask
    task automatic conv(input logic [15:0] p, input logic [23:0] c, input logic b);
        go <= 1'b1;
        val <= {p, c, b};
        @(posedge ref_clk);
        go <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic t_data;
        rd(IDX_SENSOR_CFG, RST_SENSOR_CFG, "sensor_config");
        rd(IDX_TB_CFG, RST_TB_CFG, "timebase_config");
        conv(16'h1234, 24'hABCDEF, 1'b0);
        chk("pin", 8'h00, {7'h0, interruptOutput});
        rd(IDX_PROX_L, 8'h34, "prox_l");
        chk("pin", 8'h01, {7'h0, interruptOutput});
        rd(IDX_PROX_H, 8'h12, "prox_h");
        rd(IDX_FREQ_L, 8'hEF, "freq_l");
        rd(IDX_FREQ_M, 8'hCD, "freq_m");
        rd(IDX_FREQ_H, 8'hAB, "freq_h");
        conv(16'h0005, 24'h000001, 1'b1);
        rd(IDX_PROX_L, 8'hFF, "clip_l");
        rd(IDX_PROX_H, 8'hFF, "clip_h");
    endtask
    task automatic t_modes;
        logic [15:0] pv [5] = '{16'h0100, 16'h0200, 16'h00C0, 16'h0080, 16'h0040};
        logic [7:0] pe [5] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h01};
        apb(1'b1, IDX_THR_HI_L, 8'h00);
        apb(1'b1, IDX_THR_HI_H, 8'h01);
        apb(1'b1, IDX_THR_LO_L, 8'h80);
        apb(1'b1, IDX_INT_CFG, 8'h01);
        for (int i = 0; i < 5; i++) begin
            conv(pv[i], 24'h000010, 1'b0);
            chk("cmp_pin", pe[i], {7'h0, interruptOutput});
        end
        apb(1'b1, IDX_INT_CFG, 8'h02);
        conv(16'h0200, 24'h000010, 1'b0);
        conv(16'h0010, 24'h000010, 1'b0);
        chk("wake_pin", 8'h00, {7'h0, interruptOutput});
        rd(IDX_STATUS, 8'h60, "status");
        apb(1'b1, IDX_INT_CFG, 8'h03);
        chk("wake_off", 8'h01, {7'h0, interruptOutput});
        apb(1'b1, IDX_INT_CFG, 8'h02);
        chk("wake_rearm", 8'h01, {7'h0, interruptOutput});
        apb(1'b1, IDX_INT_CFG, 8'h00);
    endtask
    task automatic t_regs;
        apb(1'b1, IDX_EVT_MASK, 8'h01);
        apb(1'b1, IDX_EVT_STAT, 8'h07);
        chk("irq_clear", 8'h00, {7'h0, irq});
        conv(16'h0010, 24'h000010, 1'b0);
        chk("irq_set", 8'h01, {7'h0, irq});
        apb(1'b1, IDX_EVT_MASK, 8'h00);
        chk("irq_masked", 8'h00, {7'h0, irq});
        apb(1'b1, IDX_EVT_MASK, 8'h01);
        rd(IDX_EVT_STAT, 8'h01, "evt_stat");
        apb(1'b1, IDX_EVT_STAT, 8'h01);
        chk("irq_w1c", 8'h00, {7'h0, irq});
        apb(1'b0, 8'h30, 8'h00);
        chk("slverr", 8'h01, {7'h0, errv});
        apb(1'b1, IDX_PROX_L, 8'h55);
        rd(IDX_PROX_L, 8'h10, "prox_ro");
        apb(1'b1, IDX_SENSOR_CFG, 8'h1D);
        chk("resp", 8'h05, {5'h0, tbCtl.respTime});
        apb(1'b1, IDX_TB_CFG, 8'h02);
        chk("tb_sel", 8'h02, {6'h0, tbCtl.crystalSel, tbCtl.oscPowerDown});
        apb(1'b1, IDX_IMPEDANCE_FLOOR_SETTING, 8'h2A);
        chk("floor", 8'h2A, floorSet);
        apb(1'b1, IDX_IMPEDANCE_CEILING_SETTING, 8'h33);
        chk("ceiling", 8'h33, ceilSet);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        t_data;
        t_modes;
        t_regs;
        give_verdict;
    end
    initial begin
        #100000;
        miscompares++;
        give_verdict;
    end
endmodule

// file: sim/isr_front_end_model.sv
// Front-end model: one conversion per request, as a one-cycle pulse.
// Assumes req is a one-cycle pulse launched just after an edge.
`timescale 1ns/1ps
module isr_front_end_model (
    input  wire logic               ref_clk,
    input  wire logic               req,
    input  wire isr_pkg::isr_conv_t val,
    output logic                    convValid = 1'b0,
    output isr_pkg::isr_conv_t      convData = '0
);
    import isr_pkg::*;
    // Stale data outside the pulse changes every cycle
    always_ff @(posedge ref_clk) begin
        convValid <= req;
        convData  <= req ? val : ~convData;
    end
endmodule

// file: sim/isr_readout_chk.sv
// Checker for isr_readout: APB answer, timebase fields, interrupt pin.
// Assumes it is bound to isr_readout and sees its ports only.
`timescale 1ns/1ps
module isr_readout_chk (
    input wire logic                 ref_clk,
    input wire logic                 rstn,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [11:0]          paddr,
    input wire logic [31:0]          pwdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic                 convValid,
    input wire isr_pkg::isr_tb_ctl_t tbCtl,
    input wire logic                 interruptOutput
);
    import isr_pkg::*;
    logic [2:0] mode;
    logic [2:0] wrQ;
    wire logic       acc  = psel && penable;
    wire logic [7:0] idx  = paddr[9:2];
    wire logic       rd21 = psel && !pwrite && idx == IDX_PROX_L;
    // Shadow of the pin mode, so pin rules apply only in their mode
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            mode <= 3'h0;
            wrQ  <= 3'h0;
        end else begin
            wrQ <= pwdata[2:0];
            if (acc && pwrite && idx == IDX_INT_CFG) begin
                mode <= pwdata[2:0];
            end
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    sequence s_data_ready_behaviour; mode == 3'h0 && convValid; endsequence
    sequence s_quiet; !convValid && !psel; endsequence
    property p_rdy; acc |-> pready; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready in access");
    property p_err; acc && idx == 8'h30 |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("unmapped not refused");
    property p_data_ready_behaviour; s_data_ready_behaviour ##1 !rd21 |-> !interruptOutput; endproperty
    a_data_ready_behaviour: assert property (p_data_ready_behaviour) else $error("pin not low on data");
    // A conversion at the setup edge lands after capture, so the pin stays low
    property p_clr;
        mode == 3'h0 && acc && rd21 && !convValid && !$past(convValid) |=> interruptOutput;
    endproperty
    a_clr: assert property (p_clr) else $error("pin not released by read");
    property p_resp; acc && pwrite && idx == IDX_SENSOR_CFG |=> tbCtl.respTime == wrQ; endproperty
    a_resp: assert property (p_resp) else $error("response time wrong");
    property p_sel; acc && pwrite && idx == IDX_TB_CFG |=> tbCtl.crystalSel == wrQ[1]; endproperty
    a_sel: assert property (p_sel) else $error("timebase select wrong");
    property p_hold; ((mode == 3'h1) and s_quiet) |=> $stable(interruptOutput); endproperty
    a_hold: assert property (p_hold) else $error("comparator pin moved");
    property p_wake; mode == 3'h2 && !interruptOutput && !psel |=> !interruptOutput; endproperty
    a_wake: assert property (p_wake) else $error("wake pin released");
endmodule

bind isr_readout isr_readout_chk chk (.ref_clk(ref_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .convValid(convValid), .tbCtl(tbCtl), .interruptOutput(interruptOutput));

// file: verilog/isr_readout.sv
// Digital readout of an inductance-to-digital converter: result registers,
// threshold logic, interrupt output and an APB slave for the registers.
// Assumes the analog core delivers one conversion as a one-cycle pulse in
// the ref_clk domain; the timebase pins are handled by the analog oscillator.
//
// Contract
// - An impedance below the programmed floor makes the result read full scale.
// - The impedance result is two bytes, low byte at 0x21 and high at 0x22.
// - The counter is timed by an external 8 MHz clock or a crystal on the pins.
// - The timebase config register selects external clock or crystal.
// - The frequency count is published over three bytes 0x23 to 0x25.
// - The response time field of sensor config scales the counting interval.
// - The interrupt output runs in comparator, wake-up or data-ready mode.
// - High and low thresholds are separately programmable.
// - Comparator mode sets above the high and clears below the low threshold.
// - Wake-up mode sets above high and holds until wake-up mode is disabled.
// - Data-ready mode asserts on new data and clears on a read of 0x21.
`timescale 1ns/1ps
module isr_readout (
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               rstn,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic                    pready,
    output logic [31:0]             prdata,
    output logic                    pslverr,
    // Conversion from analog core
    input  wire logic               convValid,
    input  wire isr_pkg::isr_conv_t convData,
    // Timebase control to oscillator, range settings to front end
    output isr_pkg::isr_tb_ctl_t    tbCtl,
    output logic [7:0]              impedanceFloorSetting,
    output logic [7:0]              impedanceCeilingSetting,
    // Interrupts
    output logic                    interruptOutput,
    output logic                    irq
);
    import isr_pkg::*;

    logic [7:0]    sensorCfg;
    logic [7:0]    tbCfg;
    logic [15:0]   thrHi;
    logic [15:0]   thrLo;
    isr_int_mode_t intMode;
    logic [15:0]   prox;
    logic [23:0]   count;
    logic          cmpState;
    logic          wakeState;
    logic          drdyState;
    logic [EV_W-1:0] evtStat;
    logic [EV_W-1:0] evtMask;
    logic [EV_W-1:0] evtSet;
    logic          wrEn;
    logic          rdEn;
    logic [7:0]    idx;
    logic          mapped;
    logic [7:0]    rdByte;
    logic [15:0]   next_prox;
    logic          readProxLow;
    logic          readActive;
    logic          rdSetup;
    logic          proxLowSetup;
    logic          convSinceCapture;
    logic          wrCeiling;
    logic          wrFloor;
    logic          wrSensorCfg;
    logic          wrTbCfg;
    logic          wrThrHiL;
    logic          wrThrHiH;
    logic          wrThrLoL;
    logic          wrThrLoH;
    logic          wrIntCfg;
    logic          wrEvtMask;
    logic          wrEvtStat;
    logic [EV_W-1:0] evtClr;

    assign idx    = paddr[ADDR_LSB +: 8];
    assign wrEn   = psel && penable && pwrite;
    assign rdEn   = psel && penable && !pwrite;
    assign rdSetup = psel && !penable && !pwrite;
    assign pready = 1'b1;

    // Clip rather than wrap when the tank impedance sinks under the floor
    assign next_prox = convData.below_floor ? PROX_FULL : convData.prox;

    always_comb begin
        mapped = 1'b1;
        rdByte = 8'h00;
        case (idx)
            IDX_IMPEDANCE_CEILING_SETTING:     rdByte = impedanceCeilingSetting;
            IDX_IMPEDANCE_FLOOR_SETTING:     rdByte = impedanceFloorSetting;
            IDX_SENSOR_CFG: rdByte = sensorCfg;
            IDX_TB_CFG:     rdByte = tbCfg;
            IDX_THR_HI_L:   rdByte = thrHi[7:0];
            IDX_THR_HI_H:   rdByte = thrHi[15:8];
            IDX_THR_LO_L:   rdByte = thrLo[7:0];
            IDX_THR_LO_H:   rdByte = thrLo[15:8];
            IDX_INT_CFG:    rdByte = {5'h00, intMode};
            IDX_EVT_STAT:   rdByte = {5'h00, evtStat};
            IDX_EVT_MASK:   rdByte = {5'h00, evtMask};
            IDX_STATUS:     rdByte = {1'b0, drdyState, wakeState, cmpState, 4'h0};
            IDX_PROX_L:     rdByte = prox[7:0];
            IDX_PROX_H:     rdByte = prox[15:8];
            IDX_FREQ_L:     rdByte = count[7:0];
            IDX_FREQ_M:     rdByte = count[15:8];
            IDX_FREQ_H:     rdByte = count[23:16];
            default:        mapped = 1'b0;
        endcase
    end

    assign pslverr = psel && penable && !mapped;

    // Captured in the setup cycle so the byte stands at the access edge
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= APB_ZERO;
        end else if (rdSetup) begin
            prdata <= {24'h000000, rdByte};
        end
    end

    // One write strobe per register, raised in the access cycle only
    assign wrCeiling   = wrEn && idx == IDX_IMPEDANCE_CEILING_SETTING;
    assign wrFloor     = wrEn && idx == IDX_IMPEDANCE_FLOOR_SETTING;
    assign wrSensorCfg = wrEn && idx == IDX_SENSOR_CFG;
    assign wrTbCfg     = wrEn && idx == IDX_TB_CFG;
    assign wrThrHiL    = wrEn && idx == IDX_THR_HI_L;
    assign wrThrHiH    = wrEn && idx == IDX_THR_HI_H;
    assign wrThrLoL    = wrEn && idx == IDX_THR_LO_L;
    assign wrThrLoH    = wrEn && idx == IDX_THR_LO_H;
    assign wrIntCfg    = wrEn && idx == IDX_INT_CFG;
    assign wrEvtMask   = wrEn && idx == IDX_EVT_MASK;
    assign wrEvtStat   = wrEn && idx == IDX_EVT_STAT;

    // Range settings go straight to the analog front end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            impedanceCeilingSetting <= RST_IMPEDANCE_CEILING_SETTING;
        end else if (wrCeiling) begin
            impedanceCeilingSetting <= pwdata[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            impedanceFloorSetting <= RST_IMPEDANCE_FLOOR_SETTING;
        end else if (wrFloor) begin
            impedanceFloorSetting <= pwdata[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sensorCfg <= RST_SENSOR_CFG;
        end else if (wrSensorCfg) begin
            sensorCfg <= pwdata[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tbCfg <= RST_TB_CFG;
        end else if (wrTbCfg) begin
            tbCfg <= pwdata[7:0];
        end
    end

    // Threshold bytes land one at a time; a half-written pair compares as is
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            thrHi <= RST_THR_HI;
        end else if (wrThrHiL) begin
            thrHi[7:0] <= pwdata[7:0];
        end else if (wrThrHiH) begin
            thrHi[15:8] <= pwdata[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            thrLo <= RST_THR_LO;
        end else if (wrThrLoL) begin
            thrLo[7:0] <= pwdata[7:0];
        end else if (wrThrLoH) begin
            thrLo[15:8] <= pwdata[7:0];
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            intMode <= ISR_INT_DATA_READY_BEHAVIOUR;
        end else if (wrIntCfg) begin
            intMode <= isr_int_mode_t'(pwdata[2:0]);
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            evtMask <= '0;
        end else if (wrEvtMask) begin
            evtMask <= pwdata[EV_W-1:0];
        end
    end

    // Oscillator takes its mode and counting window straight from config
    assign tbCtl.crystalSel   = tbCfg[TB_SEL_BIT];
    assign tbCtl.oscPowerDown = tbCfg[TB_PD_BIT];
    assign tbCtl.respTime     = sensorCfg[RESP_LSB +: RESP_W];

    // Both results latched in one edge so a burst read sees one conversion
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            prox  <= '0;
            count <= '0;
        end else if (convValid) begin
            prox  <= next_prox;
            count <= convData.count;
        end
    end

    // Hysteresis comparator
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cmpState <= 1'b0;
        end else if (convValid) begin
            if (next_prox > thrHi) begin
                cmpState <= 1'b1;
            end else if (next_prox < thrLo) begin
                cmpState <= 1'b0;
            end
        end
    end

    // Wake latch held until software leaves wake-up mode
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wakeState <= 1'b0;
        end else if (intMode != ISR_INT_WAKE) begin
            wakeState <= 1'b0;
        end else if (convValid && next_prox > thrHi) begin
            wakeState <= 1'b1;
        end
    end

    // Data ready: new data wins over a simultaneous read
    assign readProxLow = rdEn && idx == IDX_PROX_L;
    assign readActive  = psel && !pwrite && idx == IDX_PROX_L;
    assign proxLowSetup = rdSetup && idx == IDX_PROX_L;

    // A conversion at or after the byte capture must not be cleared unseen
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            convSinceCapture <= 1'b0;
        end else if (proxLowSetup) begin
            convSinceCapture <= convValid;
        end else if (convValid) begin
            convSinceCapture <= 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            drdyState <= 1'b0;
        end else if (convValid) begin
            drdyState <= 1'b1;
        end else if (readProxLow && !convSinceCapture) begin
            drdyState <= 1'b0;
        end
    end

    // Active low pin; in data-ready mode a read of 0x21 under way releases the pin during its setup and access cycles
    always_comb begin
        case (intMode)
            ISR_INT_CMP:  interruptOutput = !cmpState;
            ISR_INT_WAKE: interruptOutput = !wakeState;
            ISR_INT_DATA_READY_BEHAVIOUR: interruptOutput = !(drdyState && !readActive);
            default:      interruptOutput = 1'b1;
        endcase
    end

    // Sticky events, write one to clear, set beats clear
    assign evtSet[EV_DATA] = convValid;
    assign evtSet[EV_CMP]  = convValid && !cmpState && next_prox > thrHi;
    assign evtSet[EV_WAKE] = convValid && intMode == ISR_INT_WAKE && next_prox > thrHi;

    assign evtClr = wrEvtStat ? pwdata[EV_W-1:0] : '0;

    for (genvar i = 0; i < EV_W; i++) begin : g_evt
        isr_sticky_bit #(
            .RST_VAL (1'b0)
        ) u_evt (
            .ref_clk (ref_clk),
            .rstn    (rstn),
            .setEvt  (evtSet[i]),
            .clrEvt  (evtClr[i]),
            .flag    (evtStat[i])
        );
    end

    assign irq = |(evtStat & evtMask);

endmodule

// One event flag of the sticky status; a set beats a clear in the same cycle
module isr_sticky_bit #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rstn,
    // Event and write-one clear
    input  wire logic setEvt,
    input  wire logic clrEvt,
    // Held flag
    output logic      flag
);
    import isr_pkg::*;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            flag <= RST_VAL;
        end else if (setEvt) begin
            flag <= 1'b1;
        end else if (clrEvt) begin
            flag <= 1'b0;
        end
    end

endmodule
